// File: core/bcd_adc_seq.sv
`default_nettype none

module bcd_adc_seq (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Request
    input wire logic convert_req_i,
    // Converter handshake
    input wire logic adc_done_i,
    output logic adc_start_o,
    // Status
    output logic busy_o,
    output logic data_ready_o
);

    bcd_pkg::bcd_adc_state_t state_r;
    bcd_pkg::bcd_adc_state_t state_nxt;
    logic done_meta_r;
    logic done_sync_r;
    logic done_prev_r;
    logic ready_r;
    logic ready_nxt;
    logic start_r;
    logic start_nxt;
    logic done_rise;

    // ----------------------------------------
    // Done input synchroniser
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_meta_r <= 1'b0;
            done_sync_r <= 1'b0;
            done_prev_r <= 1'b0;
        end else begin
            done_meta_r <= adc_done_i;
            done_sync_r <= done_meta_r;
            done_prev_r <= done_sync_r;
        end
    end

    assign done_rise = done_sync_r & ~done_prev_r;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        ready_nxt = ready_r;
        start_nxt = 1'b0;
        unique case (state_r)
            bcd_pkg::BCD_ADC_IDLE: begin
                if (convert_req_i) begin
                    state_nxt = bcd_pkg::BCD_ADC_START;
                    start_nxt = 1'b1;
                    ready_nxt = 1'b0;
                end
            end
            bcd_pkg::BCD_ADC_START: begin
                state_nxt = bcd_pkg::BCD_ADC_WAIT;
            end
            bcd_pkg::BCD_ADC_WAIT: begin
                if (done_rise) begin
                    state_nxt = bcd_pkg::BCD_ADC_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = bcd_pkg::BCD_ADC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= bcd_pkg::BCD_ADC_IDLE;
            ready_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= ready_nxt;
            start_r <= start_nxt;
        end
    end

    assign adc_start_o = start_r;
    assign busy_o = (state_r != bcd_pkg::BCD_ADC_IDLE);
    assign data_ready_o = ready_r;

endmodule : bcd_adc_seq

`default_nettype wire

// File: core/bcd_regs.sv
`include "bcd_defs.svh"

`default_nettype none

module bcd_regs (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Register port from the serial host controller
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Analog side status
    input wire logic [3:0] low_dim_i,
    input wire logic dim_pin_i,
    input wire logic adc_done_i,
    // Converter control
    output logic adc_start_o,
    output logic data_ready_o,
    output logic converter_outputs_on_o,
    output logic phase_shift_on_o,
    output logic [3:0] led_current_code_o,
    output logic [6:0] led_current_ma_o,
    // Dimming control
    output logic external_brightness_select_o,
    output logic hybrid_brightness_enable_o,
    output logic [1:0] hybrid_crossover_threshold_o,
    output logic [12:0] threshold_x100_o,
    output logic dim_level_o,
    output logic [17:0] on_time_ch1_o,
    output logic [23:0] on_time_ch1_ns_o
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    function automatic logic [12:0] thr_x100(input logic [1:0] code);
        unique case (bcd_pkg::bcd_thr_t'(code))
            bcd_pkg::BCD_THR_6P25: thr_x100 = 13'h0271;
            bcd_pkg::BCD_THR_12P5: thr_x100 = 13'h04E2;
            bcd_pkg::BCD_THR_25: thr_x100 = 13'h09C4;
            bcd_pkg::BCD_THR_50: thr_x100 = 13'h1388;
        endcase
    endfunction : thr_x100

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic outputs_on_r;
    logic outputs_on_nxt;
    logic phase_r;
    logic phase_nxt;
    logic [3:0] code_r;
    logic [3:0] code_nxt;
    logic ext_r;
    logic ext_nxt;
    logic hyb_r;
    logic hyb_nxt;
    logic [1:0] thr_r;
    logic [1:0] thr_nxt;
    logic [7:0] ton_high_r;
    logic [7:0] ton_high_nxt;
    logic [7:0] ton_mid_r;
    logic [7:0] ton_mid_nxt;
    logic [1:0] ton_lsb_r;
    logic [1:0] ton_lsb_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic [3:0] flags_meta_r;
    logic [3:0] flags_sync_r;
    logic dim_meta_r;
    logic dim_sync_r;
    logic [6:0] cur_ma_r;
    logic [6:0] cur_ma_nxt;
    logic [12:0] thr_pct_r;
    logic [12:0] thr_pct_nxt;
    logic [17:0] on_time_r;
    logic [17:0] on_time_nxt;
    logic [23:0] on_time_ns_r;
    logic [23:0] on_time_ns_nxt;
    logic dim_level_r;
    logic dim_level_nxt;
    logic convert_req;
    logic conv_busy;
    logic conv_start;
    logic conv_ready;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flags_meta_r <= 4'h0;
            flags_sync_r <= 4'h0;
            dim_meta_r <= 1'b0;
            dim_sync_r <= 1'b0;
        end else begin
            flags_meta_r <= low_dim_i;
            flags_sync_r <= flags_meta_r;
            dim_meta_r <= dim_pin_i;
            dim_sync_r <= dim_meta_r;
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_comb begin
        outputs_on_nxt = outputs_on_r;
        phase_nxt = phase_r;
        code_nxt = code_r;
        ext_nxt = ext_r;
        hyb_nxt = hyb_r;
        thr_nxt = thr_r;
        ton_high_nxt = ton_high_r;
        ton_mid_nxt = ton_mid_r;
        ton_lsb_nxt = ton_lsb_r;
        if (reg_wr_i && hit(reg_addr_i, `BCD_ADDR_CUR_EN)) begin
            outputs_on_nxt = reg_wdata_i[`BCD_BIT_OUTPUTS_ON];
            phase_nxt = reg_wdata_i[`BCD_BIT_PHASE_SHIFT];
            code_nxt = reg_wdata_i[`BCD_CODE_MSB:0];
        end
        if (reg_wr_i && hit(reg_addr_i, `BCD_ADDR_MODE)) begin
            ext_nxt = reg_wdata_i[`BCD_BIT_EXT_SELECT];
            hyb_nxt = reg_wdata_i[`BCD_BIT_HYBRID];
            thr_nxt = reg_wdata_i[`BCD_THR_MSB:0];
        end
        if (reg_wr_i && hit(reg_addr_i, `BCD_ADDR_TON1_HIGH)) begin
            ton_high_nxt = reg_wdata_i;
        end
        if (reg_wr_i && hit(reg_addr_i, `BCD_ADDR_TON1_MID)) begin
            ton_mid_nxt = reg_wdata_i;
        end
        if (reg_wr_i && hit(reg_addr_i, `BCD_ADDR_TON_LSB)) begin
            ton_lsb_nxt = reg_wdata_i[1:0];
        end
    end

    assign convert_req = reg_wr_i && hit(reg_addr_i, `BCD_ADDR_CUR_EN)
        && reg_wdata_i[`BCD_BIT_CONVERT];

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            outputs_on_r <= `BCD_RST_OUTPUTS_ON;
            phase_r <= `BCD_RST_PHASE_SHIFT;
            code_r <= `BCD_RST_CODE;
            ext_r <= `BCD_RST_EXT_SELECT;
            hyb_r <= `BCD_RST_HYBRID;
            thr_r <= `BCD_RST_THR;
            ton_high_r <= `BCD_RST_TON_HIGH;
            ton_mid_r <= `BCD_RST_TON_MID;
            ton_lsb_r <= `BCD_RST_TON_LSB;
        end else begin
            outputs_on_r <= outputs_on_nxt;
            phase_r <= phase_nxt;
            code_r <= code_nxt;
            ext_r <= ext_nxt;
            hyb_r <= hyb_nxt;
            thr_r <= thr_nxt;
            ton_high_r <= ton_high_nxt;
            ton_mid_r <= ton_mid_nxt;
            ton_lsb_r <= ton_lsb_nxt;
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (hit(reg_addr_i, `BCD_ADDR_CUR_EN)) begin
            rdata_nxt = {1'b0, conv_busy, outputs_on_r, phase_r, code_r};
        end else if (hit(reg_addr_i, `BCD_ADDR_MODE)) begin
            rdata_nxt = {flags_sync_r, ext_r, hyb_r, thr_r};
        end else if (hit(reg_addr_i, `BCD_ADDR_TON1_HIGH)) begin
            rdata_nxt = ton_high_r;
        end else if (hit(reg_addr_i, `BCD_ADDR_TON1_MID)) begin
            rdata_nxt = ton_mid_r;
        end else if (hit(reg_addr_i, `BCD_ADDR_TON_LSB)) begin
            rdata_nxt = {6'h00, ton_lsb_r};
        end
        if (!reg_rd_i) begin
            rdata_nxt = rdata_r;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= reg_rd_i;
        end
    end

    // ----------------------------------------
    // Derived control values
    // ----------------------------------------
    always_comb begin
        on_time_nxt = {ton_high_r, ton_mid_r, ton_lsb_r};
        cur_ma_nxt = `BCD_CUR_BASE_MA + 7'(code_r * `BCD_CUR_STEP_MA);
        thr_pct_nxt = thr_x100(thr_r);
        on_time_ns_nxt = 24'(on_time_nxt) * `BCD_ON_TIME_UNIT_NS;
        dim_level_nxt = ext_r ? dim_sync_r : 1'b0;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cur_ma_r <= `BCD_RST_CUR_MA;
            thr_pct_r <= `BCD_RST_THR_X100;
            on_time_r <= {`BCD_RST_TON_HIGH, `BCD_RST_TON_MID, `BCD_RST_TON_LSB};
            on_time_ns_r <= `BCD_RST_ON_TIME_NS;
            dim_level_r <= 1'b0;
        end else begin
            cur_ma_r <= cur_ma_nxt;
            thr_pct_r <= thr_pct_nxt;
            on_time_r <= on_time_nxt;
            on_time_ns_r <= on_time_ns_nxt;
            dim_level_r <= dim_level_nxt;
        end
    end

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    bcd_adc_seq i_bcd_adc_seq (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .convert_req_i(convert_req),
        .adc_done_i(adc_done_i),
        .adc_start_o(conv_start),
        .busy_o(conv_busy),
        .data_ready_o(conv_ready)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign adc_start_o = conv_start;
    assign data_ready_o = conv_ready;
    assign converter_outputs_on_o = outputs_on_r;
    assign phase_shift_on_o = phase_r;
    assign led_current_code_o = code_r;
    assign led_current_ma_o = cur_ma_r;
    assign external_brightness_select_o = ext_r;
    assign hybrid_brightness_enable_o = hyb_r;
    assign hybrid_crossover_threshold_o = thr_r;
    assign threshold_x100_o = thr_pct_r;
    assign dim_level_o = dim_level_r;
    assign on_time_ch1_o = on_time_r;
    assign on_time_ch1_ns_o = on_time_ns_r;

endmodule : bcd_regs

`default_nettype wire

// File: shared/bcd_defs.svh
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCD_ADDR_CUR_EN        8'h02
`define BCD_ADDR_MODE          8'h03
`define BCD_ADDR_TON1_HIGH     8'h04
`define BCD_ADDR_TON1_MID      8'h05
`define BCD_ADDR_TON_LSB       8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BCD_BIT_CONVERT        6
`define BCD_BIT_OUTPUTS_ON     5
`define BCD_BIT_PHASE_SHIFT    4
`define BCD_CODE_MSB           3
`define BCD_FLAGS_LSB          4
`define BCD_BIT_EXT_SELECT     3
`define BCD_BIT_HYBRID         2
`define BCD_THR_MSB            1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BCD_RST_OUTPUTS_ON     1'b0
`define BCD_RST_PHASE_SHIFT    1'b1
`define BCD_RST_CODE           4'hB
`define BCD_RST_EXT_SELECT     1'b1
`define BCD_RST_HYBRID         1'b0
`define BCD_RST_THR            2'h0
`define BCD_RST_TON_HIGH       8'h7F
`define BCD_RST_TON_MID        8'h7F
`define BCD_RST_TON_LSB        2'h3
`define BCD_RST_CUR_MA         7'h64
`define BCD_RST_THR_X100       13'h0271
`define BCD_RST_ON_TIME_NS     24'h639BCE

// ----------------------------------------
// Scaling
// ----------------------------------------
`define BCD_CUR_BASE_MA        7'h2D
`define BCD_CUR_STEP_MA        7'h05
`define BCD_ON_TIME_UNIT_NS    24'h000032

`endif

// File: shared/bcd_pkg.sv
`default_nettype none

package bcd_pkg;

    // ----------------------------------------
    // Conversion sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        BCD_ADC_IDLE,
        BCD_ADC_START,
        BCD_ADC_WAIT
    } bcd_adc_state_t;

    // ----------------------------------------
    // Hybrid crossover threshold codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        BCD_THR_6P25 = 2'h0,
        BCD_THR_12P5 = 2'h1,
        BCD_THR_25 = 2'h2,
        BCD_THR_50 = 2'h3
    } bcd_thr_t;

endpackage : bcd_pkg

`default_nettype wire

// File: verification/bcd_adc_model.sv
`default_nettype none

module bcd_adc_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Converter handshake
    input wire logic start_i,
    input wire logic slow_i,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_r;

    // Done rises after a short or long run, holds four cycles
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_r <= 0;
            done_o <= 1'b0;
        end else if (start_i) begin
            cnt_r <= slow_i ? 40 : 5;
            done_o <= 1'b0;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
            done_o <= (cnt_r <= 4);
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule : bcd_adc_model

`default_nettype wire

// File: verification/bcd_regs_chk.sv
`default_nettype none

module bcd_regs_chk (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rvalid_o,
    // Converter
    input wire logic adc_done_i,
    input wire logic adc_start_o,
    input wire logic data_ready_o,
    input wire logic converter_outputs_on_o,
    input wire logic phase_shift_on_o,
    input wire logic [3:0] led_current_code_o,
    input wire logic [6:0] led_current_ma_o,
    // Dimming
    input wire logic external_brightness_select_o,
    input wire logic hybrid_brightness_enable_o,
    input wire logic [1:0] hybrid_crossover_threshold_o,
    input wire logic [12:0] threshold_x100_o,
    input wire logic dim_level_o,
    input wire logic [17:0] on_time_ch1_o,
    input wire logic [23:0] on_time_ch1_ns_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    // ----
    // Sequences
    // ----
    sequence wr_cur;
        reg_wr_i && reg_addr_i == 8'h02;
    endsequence
    sequence wr_mode;
        reg_wr_i && reg_addr_i == 8'h03;
    endsequence
    sequence start_pulse;
        adc_start_o && !data_ready_o ##1 !adc_start_o;
    endsequence

    rvalid_pulse_a: assert property (
        reg_rvalid_o == $past(reg_rd_i)) else $error("read strobe not answered");
    start_cause_a: assert property (
        adc_start_o |-> $past(reg_wr_i && reg_addr_i == 8'h02 && reg_wdata_i[6]) ##0 start_pulse)
        else $error("bad conversion start");
    ready_cause_a: assert property (
        $rose(data_ready_o) |-> $past(adc_done_i, 2)) else $error("ready without done");
    cur_write_a: assert property (
        wr_cur |=> converter_outputs_on_o == $past(reg_wdata_i[5])
        && phase_shift_on_o == $past(reg_wdata_i[4])
        && led_current_code_o == $past(reg_wdata_i[3:0])) else $error("current write lost");
    mode_write_a: assert property (
        wr_mode |=> external_brightness_select_o == $past(reg_wdata_i[3])
        && hybrid_brightness_enable_o == $past(reg_wdata_i[2])
        && hybrid_crossover_threshold_o == $past(reg_wdata_i[1:0])) else $error("mode write lost");
    ma_scale_a: assert property (
        led_current_ma_o == 7'h2D + 7'h05 * $past(led_current_code_o)) else $error("bad mA");
    thr_scale_a: assert property (
        threshold_x100_o == ($past(hybrid_crossover_threshold_o) == 2'h0 ? 13'h0271 :
        $past(hybrid_crossover_threshold_o) == 2'h1 ? 13'h04E2 :
        $past(hybrid_crossover_threshold_o) == 2'h2 ? 13'h09C4 : 13'h1388))
        else $error("bad threshold");
    ns_scale_a: assert property (
        on_time_ch1_ns_o == 24'(on_time_ch1_o) * 24'h000032) else $error("bad on-time ns");
    dim_route_a: assert property (
        !external_brightness_select_o |=> !dim_level_o) else $error("pin leaks to dimming");
endmodule : bcd_regs_chk

bind bcd_regs bcd_regs_chk i_bcd_regs_chk (.ref_clk_i, .reset_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rvalid_o, .adc_done_i, .adc_start_o, .data_ready_o,
    .converter_outputs_on_o, .phase_shift_on_o, .led_current_code_o, .led_current_ma_o,
    .external_brightness_select_o, .hybrid_brightness_enable_o,
    .hybrid_crossover_threshold_o, .threshold_x100_o, .dim_level_o, .on_time_ch1_o,
    .on_time_ch1_ns_o);

`default_nettype wire

// File: verification/test_bcd_regs.sv
`default_nettype none

module test_bcd_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [3:0] low_dim_i = 4'h0;
    logic dim_pin_i = 1'b0;
    logic slow = 1'b0;
    logic adc_done_i;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o, adc_start_o, data_ready_o, dim_level_o;
    logic [6:0] led_current_ma_o;
    logic [12:0] threshold_x100_o;
    logic [17:0] on_time_ch1_o;
    logic [23:0] on_time_ch1_ns_o;
    logic [23:0] thr_tab [4] = '{24'h000271, 24'h0004E2, 24'h0009C4, 24'h001388};
    int error_cnt = 0;
    int total_checks = 0;
    int n;
    int k;

    always #50 ref_clk_i = ~ref_clk_i;

    bcd_regs i_bcd_regs (.ref_clk_i, .reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .low_dim_i, .dim_pin_i, .adc_done_i,
        .adc_start_o, .data_ready_o, .converter_outputs_on_o(), .phase_shift_on_o(),
        .led_current_code_o(), .led_current_ma_o, .external_brightness_select_o(),
        .hybrid_brightness_enable_o(), .hybrid_crossover_threshold_o(), .threshold_x100_o,
        .dim_level_o, .on_time_ch1_o, .on_time_ch1_ns_o);
    bcd_adc_model i_bcd_adc_model (.ref_clk_i, .reset_i, .start_i(adc_start_o),
        .slow_i(slow), .done_o(adc_done_i));

    // ----
    // Access tasks
    // ----
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(24'({reg_rvalid_o, reg_rdata_o}), 24'({1'b1, e}));
    endtask : rd
    task automatic wait_n(input int c);
        repeat (c) @(posedge ref_clk_i);
        #1;
    endtask : wait_n
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (3000) @(posedge ref_clk_i);
        error_cnt++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(8'h02, 8'h1B);
        rd(8'h03, 8'h08);
        rd(8'h04, 8'h7F);
        rd(8'h05, 8'h7F);
        rd(8'h0C, 8'h03);
        chk(24'(on_time_ch1_o), 24'h01FDFF);
        chk(on_time_ch1_ns_o, 24'h01FDFF * 24'h000032);
        $display("test reset done");
        for (n = 0; n < 16; n++) begin
            wr(8'h02, 8'hA0 | 8'(n));
            rd(8'h02, 8'h20 | 8'(n));
            chk(24'(led_current_ma_o), 24'h00002D + 24'(n) * 24'h000005);
        end
        $display("test current done");
        @(posedge ref_clk_i);
        low_dim_i <= 4'hA;
        for (n = 0; n < 4; n++) begin
            wr(8'h03, 8'hF4 | 8'(n));
            rd(8'h03, 8'hA4 | 8'(n));
            chk(24'(threshold_x100_o), thr_tab[n]);
        end
        @(posedge ref_clk_i);
        dim_pin_i <= 1'b1;
        wait_n(4);
        chk(24'(dim_level_o), 24'h000000);
        wr(8'h03, 8'h08);
        wait_n(4);
        chk(24'(dim_level_o), 24'h000001);
        $display("test mode done");
        wr(8'h04, 8'hA5);
        wr(8'h05, 8'h3C);
        wr(8'h0C, 8'hFE);
        wr(8'h40, 8'h55);
        rd(8'h0C, 8'h02);
        rd(8'h40, 8'h00);
        chk(24'(on_time_ch1_o), 24'h0294F2);
        chk(on_time_ch1_ns_o, 24'h0294F2 * 24'h000032);
        $display("test on-time done");
        for (n = 0; n < 2; n++) begin
            @(posedge ref_clk_i);
            slow <= n[0];
            wr(8'h02, 8'h6B);
            rd(8'h02, 8'h6B);
            for (k = 0; k < 100 && data_ready_o !== 1'b1; k++) begin
                @(posedge ref_clk_i);
                #1;
            end
            chk(24'(data_ready_o), 24'h000001);
            rd(8'h02, 8'h2B);
        end
        $display("test conversion done");
        stop_test();
    end
endmodule : test_bcd_regs

`default_nettype wire
